// file: design/gmc_cmd_top.sv
// Command interpreter for the gas module serial link.
// How it works
// R1: Commands and replies are ASCII lines closed by a single line feed.
// R2: Every command gets S or F plus line feed unless it returns data.
// R3: Host repeats its first command after power-up until S arrives.
// R4: Identifier read returns eight hex characters then line feed.
// R5: Version read returns V, dot, digit, dot, two digits, line feed.
// R6: Interrupt clear drops pending interrupt, drives line high, replies S.
// R7: Restart replies S then reboots all state like a power cycle.
// R8: Stabilization count set fails only when already set and sensor active.
// R9: Tuning select takes auto, NO2 or ozone argument and replies S.
// R10: Power up starts or resumes measurement and replies S.
// R11: Power down pauses measurement and replies S.
// R12: Air index read returns four digits, dot, one digit, line feed.
// R13: NO2 read returns four digits, dot, one digit, line feed.
// R14: Ozone read returns four digits, dot, one digit, line feed.
// R15: Presence read returns three digits of probability times hundred.
// R16: Poll replies S new data, W measuring, F sensor inactive.
// R17: Unknown or malformed lines get F; characters dropped up to line feed.
// R18: Link uses 8 data bits, no parity, one stop bit, fixed baud.
`timescale 1ns/1ps
module gmc_cmd_top import gmc_pkg::*; #(
	parameter int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT,
	parameter logic [31:0] UNIQUE_ID = 32'h1234ABCD, // Arbitrary value.
	parameter logic [11:0] FW_VERSION = 12'h100 // BCD digits, arbitrary value.
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic rxd,
	output logic txd,
	output logic int_n,
	output logic sensor_power,
	output logic [7:0] stab_count,
	output logic [1:0] tune_mode,
	input wire logic [19:0] air_index_bcd,
	input wire logic [19:0] no2_bcd,
	input wire logic [19:0] ozone_bcd,
	input wire logic [11:0] presence_bcd,
	input wire logic meas_busy,
	input wire logic result_ready
);
	initial begin
		if (BIT_CYCLES < 4) $error("gmc_cmd_top: BIT_CYCLES too small");
	end
	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] rx_data;
	logic rx_valid, tx_busy, tx_line;
	logic busy_s1_reg, busy_s2_reg, rdy_s1_reg, rdy_s2_reg, rdy_old_reg;
	// Serial framing handled in the two leaf modules. [R18]
	gmc_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
		.ref_clk(ref_clk),
		.rst(rst),
		.rx_pin(rxd),
		.rx_data(rx_data),
		.rx_valid(rx_valid)
	);
	logic [7:0] tx_byte;
	logic tx_go_reg, tx_go_next;
	gmc_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
		.ref_clk(ref_clk),
		.rst(rst),
		.tx_data(tx_byte),
		.tx_start(tx_go_reg),
		.tx_busy(tx_busy),
		.tx_pin(tx_line)
	);
	// Status lines from the measurement engine arrive from outside, so synchronise them.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy_s1_reg <= 1'b0;
			busy_s2_reg <= 1'b0;
			rdy_s1_reg <= 1'b0;
			rdy_s2_reg <= 1'b0;
			rdy_old_reg <= 1'b0;
		end else begin
			busy_s1_reg <= meas_busy;
			busy_s2_reg <= busy_s1_reg;
			rdy_s1_reg <= result_ready;
			rdy_s2_reg <= rdy_s1_reg;
			rdy_old_reg <= rdy_s2_reg;
		end
	end
	wire new_result = rdy_s2_reg & ~rdy_old_reg;
	////////////////////////////////////////////////////////////////////////////////
	// Hex and ASCII helpers.
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'hA) ? (CH_ZERO + {4'h0, n}) : (CH_A + {4'h0, n} - 8'h0A);
	endfunction : hex_char
	function automatic logic [7:0] dec_char(input logic [3:0] n);
		dec_char = CH_ZERO + {4'h0, n};
	endfunction : dec_char
	function automatic logic is_digit(input logic [7:0] c);
		is_digit = (c >= CH_ZERO) && (c <= 8'h39);
	endfunction : is_digit
	////////////////////////////////////////////////////////////////////////////////
	gmc_state_t state_reg, state_next;
	logic [7:0] line_reg [LINE_MAX];
	logic [7:0] line_next [LINE_MAX];
	logic [2:0] len_reg, len_next;
	logic ovf_reg, ovf_next;
	logic [7:0] reply_reg [REPLY_MAX];
	logic [7:0] reply_next [REPLY_MAX];
	logic [3:0] rlen_reg, rlen_next, ridx_reg, ridx_next;
	logic restart_reg, restart_next;
	logic int_pend_reg, int_pend_next;
	logic power_reg, power_next, stab_set_reg, stab_set_next, fresh_reg, fresh_next;
	logic [7:0] stab_reg, stab_next;
	logic [1:0] tune_reg, tune_next;
	logic txd_reg, txd_next;
	logic int_n_reg, int_n_next;
	logic [19:0] read_val;
	gmc_cmd_t cmd;
	// Decode the captured line; arguments must match exactly or it is malformed. [R17]
	always_comb begin
		cmd = CMD_BAD;
		if (ovf_reg) begin
			cmd = CMD_BAD;
		end else if (len_reg == 3'd2) begin
			case ({line_reg[0], line_reg[1]})
				16'h4944: cmd = CMD_ID;
				16'h5652: cmd = CMD_VER;
				16'h4349: cmd = CMD_ICLR;
				16'h5253: cmd = CMD_RESTART;
				16'h5055: cmd = CMD_PWR_UP;
				16'h5044: cmd = CMD_PWR_DN;
				16'h4151: cmd = CMD_AIR;
				16'h4E4F: cmd = CMD_NO2;
				16'h4F33: cmd = CMD_OZONE;
				16'h504E: cmd = CMD_PRES;
				16'h4E52: cmd = CMD_POLL;
				default: cmd = CMD_BAD;
			endcase
		end else if (len_reg == 3'd3 && {line_reg[0], line_reg[1]} == 16'h4F50
				&& line_reg[2] >= CH_ZERO && line_reg[2] <= 8'h32) begin
			cmd = CMD_TUNE;
		end else if (len_reg == 3'd4 && {line_reg[0], line_reg[1]} == 16'h5353
				&& is_digit(line_reg[2]) && is_digit(line_reg[3])) begin
			cmd = CMD_STAB;
		end
	end
	// Line capture, command execution and reply streaming.
	always_comb begin
		state_next = state_reg;
		line_next = line_reg;
		len_next = len_reg;
		ovf_next = ovf_reg;
		reply_next = reply_reg;
		rlen_next = rlen_reg;
		ridx_next = ridx_reg;
		restart_next = 1'b0;
		int_pend_next = int_pend_reg | new_result; // Interrupt on every new result.
		power_next = power_reg;
		stab_set_next = stab_set_reg;
		stab_next = stab_reg;
		tune_next = tune_reg;
		fresh_next = fresh_reg | new_result;
		tx_go_next = 1'b0;
		txd_next = tx_line;
		read_val = 20'h00000;
		for (int i = 0; i < REPLY_MAX; i++) reply_next[i] = reply_reg[i];
		case (state_reg)
			ST_IDLE: begin
				if (rx_valid && rx_data != CH_LF) begin
					// Keep characters; too many marks the line malformed. [R17]
					if (len_reg < 3'(LINE_MAX)) begin
						line_next[len_reg[1:0]] = rx_data;
						len_next = len_reg + 3'd1;
					end else begin
						ovf_next = 1'b1;
					end
				end else if (rx_valid) begin
					// Line feed closes the command; every command is answered. [R1] [R2]
					len_next = 3'd0;
					ovf_next = 1'b0;
					ridx_next = 4'h0;
					rlen_next = 4'd2;
					reply_next[0] = CH_S;
					reply_next[1] = CH_LF;
					state_next = ST_SEND;
					case (cmd)
						CMD_ID: begin
							for (int i = 0; i < 8; i++)
								reply_next[i] = hex_char(UNIQUE_ID[31 - 4*i -: 4]); // [R4]
							reply_next[8] = CH_LF;
							rlen_next = 4'd9;
						end
						CMD_VER: begin
							reply_next[0] = CH_V; // [R5]
							reply_next[1] = CH_DOT;
							reply_next[2] = dec_char(FW_VERSION[11:8]);
							reply_next[3] = CH_DOT;
							reply_next[4] = dec_char(FW_VERSION[7:4]);
							reply_next[5] = dec_char(FW_VERSION[3:0]);
							reply_next[6] = CH_LF;
							rlen_next = 4'd7;
						end
						CMD_ICLR: int_pend_next = new_result; // Set wins over clear. [R6]
						CMD_RESTART: restart_next = 1'b1; // [R7]
						CMD_STAB: begin
							if (stab_set_reg && power_reg) begin
								reply_next[0] = CH_F; // [R8]
							end else begin
								stab_next = (line_reg[2] - CH_ZERO) * 8'd10 + (line_reg[3] - CH_ZERO);
								stab_set_next = 1'b1;
							end
						end
						CMD_TUNE: tune_next = line_reg[2][1:0]; // [R9]
						CMD_PWR_UP: power_next = 1'b1; // [R10]
						CMD_PWR_DN: power_next = 1'b0; // [R11]
						CMD_AIR, CMD_NO2, CMD_OZONE: begin
							// Same xxxx.x layout for all three readings. [R12] [R13] [R14]
							read_val = (cmd == CMD_AIR) ? air_index_bcd :
								(cmd == CMD_NO2) ? no2_bcd : ozone_bcd;
							for (int i = 0; i < 4; i++)
								reply_next[i] = dec_char(read_val[19 - 4*i -: 4]);
							reply_next[4] = CH_DOT;
							reply_next[5] = dec_char(read_val[3:0]);
							reply_next[6] = CH_LF;
							rlen_next = 4'd7;
							fresh_next = new_result;
						end
						CMD_PRES: begin
							for (int i = 0; i < 3; i++)
								reply_next[i] = dec_char(presence_bcd[11 - 4*i -: 4]); // [R15]
							reply_next[3] = CH_LF;
							rlen_next = 4'd4;
						end
						CMD_POLL: begin
							// Inactive beats busy beats fresh data. [R16]
							if (!power_reg) reply_next[0] = CH_F;
							else if (busy_s2_reg) reply_next[0] = CH_W;
							else if (!fresh_reg) reply_next[0] = CH_W;
						end
						default: reply_next[0] = CH_F; // [R17]
					endcase
				end
			end
			ST_SEND: begin
				// Hand one character to the transmitter, then wait for it to finish.
				tx_go_next = 1'b1;
				state_next = ST_WAIT;
			end
			ST_WAIT: begin
				if (!tx_busy && !tx_go_reg) begin
					ridx_next = ridx_reg + 4'h1;
					if (ridx_reg + 4'h1 < rlen_reg) state_next = ST_SEND;
					else if (restart_reg) state_next = ST_RESET; // Reply goes out before reboot.
					else state_next = ST_IDLE;
				end
			end
			ST_RESET: begin
				// Full reboot of all control state, as a power cycle. [R7]
				state_next = ST_IDLE;
				int_pend_next = 1'b0;
				power_next = 1'b0;
				stab_set_next = 1'b0;
				stab_next = STAB_RESET;
				tune_next = TUNE_RESET;
				fresh_next = 1'b0;
			end
			default: state_next = ST_IDLE;
		endcase
		if (state_reg != ST_IDLE && state_reg != ST_RESET) restart_next = restart_reg;
		// The pin level is kept in its own flop so no gate sits after it. [R6]
		int_n_next = ~int_pend_next;
	end
	assign tx_byte = reply_reg[ridx_reg];
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			for (int i = 0; i < LINE_MAX; i++) line_reg[i] <= 8'h00;
			for (int i = 0; i < REPLY_MAX; i++) reply_reg[i] <= 8'h00;
			len_reg <= 3'd0;
			ovf_reg <= 1'b0;
			rlen_reg <= 4'h0;
			ridx_reg <= 4'h0;
			restart_reg <= 1'b0;
			int_pend_reg <= 1'b0;
			power_reg <= 1'b0;
			stab_set_reg <= 1'b0;
			stab_reg <= STAB_RESET;
			tune_reg <= TUNE_RESET;
			fresh_reg <= 1'b0;
			tx_go_reg <= 1'b0;
			txd_reg <= 1'b1;
			int_n_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			line_reg <= line_next;
			reply_reg <= reply_next;
			len_reg <= len_next;
			ovf_reg <= ovf_next;
			rlen_reg <= rlen_next;
			ridx_reg <= ridx_next;
			restart_reg <= restart_next;
			int_pend_reg <= int_pend_next;
			power_reg <= power_next;
			stab_set_reg <= stab_set_next;
			stab_reg <= stab_next;
			tune_reg <= tune_next;
			fresh_reg <= fresh_next;
			tx_go_reg <= tx_go_next;
			txd_reg <= txd_next;
			int_n_reg <= int_n_next;
		end
	end
	// Outputs straight from flip-flops; the interrupt line is active low.
	assign txd = txd_reg;
	assign int_n = int_n_reg;
	assign sensor_power = power_reg;
	assign stab_count = stab_reg;
	assign tune_mode = tune_reg;
endmodule : gmc_cmd_top

// file: design/gmc_uart_rx.sv
// Serial byte receiver, 8 data bits, no parity, one stop bit.
`timescale 1ns/1ps
module gmc_uart_rx import gmc_pkg::*; #(
	parameter int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic rx_pin,
	output logic [7:0] rx_data,
	output logic rx_valid
);
	initial begin
		if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) $error("gmc_uart_rx: bad BIT_CYCLES");
	end
	logic s1_reg, s2_reg, busy_reg, busy_next, valid_reg, valid_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] sh_reg, sh_next;
	// Two stages before any logic sees the pin; s1 feeds s2 only.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
		end else begin
			s1_reg <= rx_pin;
			s2_reg <= s1_reg;
		end
	end
	// Start edge arms a half-bit wait so every bit is sampled mid-cell.
	always_comb begin
		busy_next = busy_reg;
		cnt_next = cnt_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		valid_next = 1'b0;
		if (!busy_reg) begin
			if (!s2_reg) begin
				busy_next = 1'b1;
				cnt_next = 16'(BIT_CYCLES / 2);
				bit_next = 4'h0;
			end
		end else if (cnt_reg != 16'h0000) begin
			cnt_next = cnt_reg - 16'h0001;
		end else begin
			cnt_next = 16'(BIT_CYCLES - 1);
			bit_next = bit_reg + 4'h1;
			if (bit_reg == 4'h0) begin
				if (s2_reg) busy_next = 1'b0; // Glitch, not a start bit.
			end else if (bit_reg <= 4'h8) begin
				sh_next = {s2_reg, sh_reg[7:1]};
			end else begin
				busy_next = 1'b0;
				valid_next = s2_reg; // Framing errors drop the byte.
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy_reg <= 1'b0;
			cnt_reg <= 16'h0000;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			valid_reg <= 1'b0;
		end else begin
			busy_reg <= busy_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
			valid_reg <= valid_next;
		end
	end
	assign rx_data = sh_reg;
	assign rx_valid = valid_reg;
endmodule : gmc_uart_rx

// file: design/gmc_uart_tx.sv
// Serial byte transmitter, 8 data bits, no parity, one stop bit.
`timescale 1ns/1ps
module gmc_uart_tx import gmc_pkg::*; #(
	parameter int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] tx_data,
	input wire logic tx_start,
	output logic tx_busy,
	output logic tx_pin
);
	initial begin
		if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) $error("gmc_uart_tx: bad BIT_CYCLES");
	end
	logic busy_reg, busy_next, pin_reg, pin_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [3:0] bit_reg, bit_next;
	logic [8:0] sh_reg, sh_next;
	// Frame is start bit, eight data bits LSB first, then stop bit.
	always_comb begin
		busy_next = busy_reg;
		pin_next = pin_reg;
		cnt_next = cnt_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		if (!busy_reg) begin
			pin_next = 1'b1;
			if (tx_start) begin
				busy_next = 1'b1;
				pin_next = 1'b0;
				sh_next = {1'b1, tx_data};
				cnt_next = 16'(BIT_CYCLES - 1);
				bit_next = 4'h0;
			end
		end else if (cnt_reg != 16'h0000) begin
			cnt_next = cnt_reg - 16'h0001;
		end else if (bit_reg == 4'h9) begin
			busy_next = 1'b0;
		end else begin
			pin_next = sh_reg[0];
			sh_next = {1'b1, sh_reg[8:1]};
			bit_next = bit_reg + 4'h1;
			cnt_next = 16'(BIT_CYCLES - 1);
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy_reg <= 1'b0;
			pin_reg <= 1'b1;
			cnt_reg <= 16'h0000;
			bit_reg <= 4'h0;
			sh_reg <= 9'h1FF;
		end else begin
			busy_reg <= busy_next;
			pin_reg <= pin_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			sh_reg <= sh_next;
		end
	end
	assign tx_busy = busy_reg;
	assign tx_pin = pin_reg;
endmodule : gmc_uart_tx

// file: pkg/gmc_pkg.sv
// Package of constants and types for the gas module command interpreter.
package gmc_pkg;
	// Character codes used on the link.
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_W = 8'h57;
	localparam logic [7:0] CH_V = 8'h56;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_A = 8'h41;
	// Longest command line kept: two letters plus two argument characters.
	localparam int LINE_MAX = 4;
	// Longest reply including line feed (eight id characters).
	localparam int REPLY_MAX = 9;
	// Serial timing at 40 MHz reference clock.
	localparam int CLK_HZ = 40000000;
	localparam int BAUD_DEFAULT = 115200;
	// Reset values of the control state.
	localparam logic [7:0] STAB_RESET = 8'h00;
	localparam logic [1:0] TUNE_RESET = 2'h0;
	// Tuning selections.
	localparam logic [1:0] TUNE_AUTO = 2'h0;
	localparam logic [1:0] TUNE_NO2 = 2'h1;
	localparam logic [1:0] TUNE_O3 = 2'h2;
	// Command identities after decoding.
	typedef enum logic [3:0] {
		CMD_ID = 4'h0,
		CMD_VER = 4'h1,
		CMD_ICLR = 4'h2,
		CMD_RESTART = 4'h3,
		CMD_STAB = 4'h4,
		CMD_TUNE = 4'h5,
		CMD_PWR_UP = 4'h6,
		CMD_PWR_DN = 4'h7,
		CMD_AIR = 4'h8,
		CMD_NO2 = 4'h9,
		CMD_OZONE = 4'hA,
		CMD_PRES = 4'hB,
		CMD_POLL = 4'hC,
		CMD_BAD = 4'hF
	} gmc_cmd_t;
	// Interpreter states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_WAIT = 2'b10,
		ST_RESET = 2'b11
	} gmc_state_t;
endpackage : gmc_pkg

// file: sim/gmc_cmd_top_assertions.sv
// Concurrent checks on the ports of the command interpreter.
`timescale 1ns/1ps
module gmc_cmd_top_assertions #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic txd,
	input wire logic int_n,
	input wire logic sensor_power,
	input wire logic [7:0] stab_count,
	input wire logic [1:0] tune_mode,
	input wire logic result_ready
);
	localparam int FRAME = 10 * BIT_CYCLES;
	int tx_pos_reg;
	int tx_pos_next;
	logic txd_last_reg;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	// Position inside an outgoing frame; zero means the line is between frames.
	always_comb begin
		tx_pos_next = 0;
		if (tx_pos_reg != 0 && tx_pos_reg < FRAME - 1) tx_pos_next = tx_pos_reg + 1;
		else if (tx_pos_reg == 0 && txd_last_reg && !txd) tx_pos_next = 1;
	end
	// Registers the frame position and the previous line level.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_pos_reg <= 0;
			txd_last_reg <= 1'b1;
		end else begin
			tx_pos_reg <= tx_pos_next;
			txd_last_reg <= txd;
		end
	end
	////////////////////////////////////////
	sequence s_frame_start;
		tx_pos_reg == 0 && txd_last_reg && !txd;
	endsequence
	sequence s_start_low;
		(!txd) [*8];
	endsequence
	chk_reset_values: assert property ($fell(rst) |-> txd && int_n && !sensor_power
		&& stab_count == 8'h00 && tune_mode == 2'h0) else $error("state not at reset values");
	chk_idle_after_rst: assert property ($fell(rst) |-> txd [*8])
		else $error("line not idle after reset");
	chk_start_bit: assert property (s_frame_start |-> s_start_low)
		else $error("start bit too short");
	chk_stop_bit: assert property (tx_pos_reg >= 9 * BIT_CYCLES |-> txd)
		else $error("stop bit low");
	chk_int_on_result: assert property ($rose(result_ready) |-> ##[1:6] !int_n)
		else $error("interrupt not raised");
	chk_int_clear_quiet: assert property ($rose(int_n) |-> txd)
		else $error("interrupt released mid frame");
	chk_state_quiet: assert property (!$stable({sensor_power, stab_count, tune_mode}) |-> txd)
		else $error("control state moved mid frame");
	chk_tune_legal: assert property (tune_mode != 2'h3)
		else $error("illegal tuning mode");
endmodule : gmc_cmd_top_assertions
bind gmc_cmd_top gmc_cmd_top_assertions #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
	.ref_clk(ref_clk),
	.rst(rst),
	.txd(txd),
	.int_n(int_n),
	.sensor_power(sensor_power),
	.stab_count(stab_count),
	.tune_mode(tune_mode),
	.result_ready(result_ready)
);

// file: sim/gmc_cmd_top_tb.sv
// Self-checking testbench for the gas module command interpreter.
`timescale 1ns/1ps
module gmc_cmd_top_tb import gmc_pkg::*;;
	localparam logic [31:0] UID = 32'h5E1F09A7; // Arbitrary value.
	localparam logic [11:0] VER = 12'h207; // Arbitrary value.
	logic ref_clk, rst, rxd, txd, int_n, sensor_power, meas_busy, result_ready;
	logic [7:0] stab_count;
	logic [1:0] tune_mode;
	logic [19:0] air_bcd, no2_bcd, oz_bcd;
	logic [11:0] pres_bcd;
	int err_count = 0;
	int compares = 0;
	int tune = 0;
	int m_pwr = 0;
	int m_fresh = 0;
	int m_stab = 0;
	gmc_cmd_top #(.BIT_CYCLES(8), .UNIQUE_ID(UID), .FW_VERSION(VER)) dut (.ref_clk(ref_clk),
		.rst(rst), .rxd(rxd), .txd(txd), .int_n(int_n), .sensor_power(sensor_power),
		.stab_count(stab_count), .tune_mode(tune_mode), .air_index_bcd(air_bcd),
		.no2_bcd(no2_bcd), .ozone_bcd(oz_bcd), .presence_bcd(pres_bcd),
		.meas_busy(meas_busy), .result_ready(result_ready));
	gmc_host_model #(.BIT_CYCLES(8)) host (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		if (err_count == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	// Sends a line and compares the whole reply; waits are bounded.
	task automatic cmd(input string line, input string exp);
		int n = 0;
		host.send_line(line);
		while (host.got.size() < exp.len() && n < 4000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 4000) begin
			err_count++;
			results();
		end
		for (int i = 0; i < exp.len(); i++) check(host.got.pop_front(), exp[i]);
		// Long enough for one more frame to arrive, so a surplus character is caught.
		repeat (90) @(posedge ref_clk);
		check(host.got.size(), 0);
		// The model follows the command once its reply is in.
		if (line == "PU") m_pwr = 1;
		if (line == "PD" || line == "RS") m_pwr = 0;
		if (line == "AQ" || line == "NO" || line == "O3" || line == "RS") m_fresh = 0;
		if (line.len() == 4 && line.substr(0, 1) == "SS") m_stab = 1;
		if (line == "RS") m_stab = 0;
	endtask : cmd
	// Expected poll reply: inactive first, then busy or stale data, else new data.
	function automatic string nr_exp();
		if (m_pwr == 0) return "F\n";
		if (meas_busy || m_fresh == 0) return "W\n";
		return "S\n";
	endfunction : nr_exp
	// Expected reply to a count set: refused only when already set and powered.
	function automatic string ss_exp();
		return (m_stab != 0 && m_pwr != 0) ? "F\n" : "S\n";
	endfunction : ss_exp
	function automatic string hex8(input logic [31:0] v);
		string s = "";
		for (int i = 7; i >= 0; i--) s = $sformatf("%s%c", s, v[4*i+:4] < 10 ?
			8'h30 + v[4*i+:4] : 8'h37 + v[4*i+:4]);
		return {s, "\n"};
	endfunction : hex8
	function automatic logic [19:0] rbcd();
		logic [19:0] r;
		for (int i = 0; i < 5; i++) r[4*i+:4] = 4'($urandom % 10);
		return r;
	endfunction : rbcd
	function automatic string dec5(input logic [19:0] v);
		return $sformatf("%04h.%1h\n", v[19:4], v[3:0]);
	endfunction : dec5
	////////////////////////////////////////
	// Free-running reference clock.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Main sequence; the model state is held in plain integers.
	initial begin
		{rst, meas_busy, result_ready, air_bcd, no2_bcd, oz_bcd, pres_bcd} = {3'b100, 72'h0};
		void'($urandom(32'h02F4154E));
		repeat (5) @(posedge ref_clk);
		#1 rst = 1'b0;
		cmd("ID", hex8(UID));
		cmd("VR", $sformatf("V.%1h.%02h\n", VER[11:8], VER[7:0]));
		cmd("NR", nr_exp());
		cmd("SS12", ss_exp());
		check(stab_count, 8'h0C);
		for (int t = 0; t < 4; t++) begin
			cmd($sformatf("OP%0d", t), t < 3 ? "S\n" : "F\n");
			if (t < 3) tune = t;
			check(tune_mode, tune);
		end
		cmd("XY", "F\n");
		cmd("PUXYZ", "F\n");
		#1 meas_busy = 1'b1;
		cmd("PU", "S\n");
		check(sensor_power, 1);
		cmd("SS34", ss_exp());
		check(stab_count, 8'h0C);
		cmd("NR", nr_exp());
		#1 meas_busy = 1'b0;
		for (int k = 0; k < 3; k++) begin
			{air_bcd, no2_bcd, oz_bcd} = {rbcd(), rbcd(), rbcd()};
			pres_bcd = 12'(rbcd());
			@(posedge ref_clk);
			#1 result_ready = 1'b1;
			repeat (4) @(posedge ref_clk);
			#1 result_ready = 1'b0;
			m_fresh = 1;
			repeat (8) @(posedge ref_clk);
			check(int_n, 0);
			cmd("NR", nr_exp());
			// Busy must win over fresh data, so the busy path is seen on its own.
			#1 meas_busy = 1'b1;
			cmd("NR", nr_exp());
			#1 meas_busy = 1'b0;
			cmd("AQ", dec5(air_bcd));
			cmd("NO", dec5(no2_bcd));
			cmd("O3", dec5(oz_bcd));
			cmd("NR", nr_exp());
			cmd("PN", $sformatf("%03h\n", pres_bcd));
			// Clearing each round makes the next low interrupt a real check.
			cmd("CI", "S\n");
			check(int_n, 1);
		end
		cmd("CI", "S\n");
		check(int_n, 1);
		cmd("PD", "S\n");
		check(sensor_power, 0);
		cmd("NR", nr_exp());
		cmd("PU", "S\n");
		cmd("RS", "S\n");
		check({sensor_power, stab_count, tune_mode}, 11'h000);
		cmd("SS34", ss_exp());
		check(stab_count, 8'h22);
		results();
	end
endmodule : gmc_cmd_top_tb

// file: sim/gmc_host_model.sv
// Host side model of the serial command link.
`timescale 1ns/1ps
module gmc_host_model import gmc_pkg::*; #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic ref_clk,
	input wire logic txd,
	output logic rxd
);
	logic [7:0] got[$];
	logic [7:0] b;
	initial rxd = 1'b1;
	////////////////////////////////////////
	// Sends one frame LSB first; the line idles high between frames.
	task automatic send_byte(input logic [7:0] d);
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			#1 rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
			repeat (BIT_CYCLES - 1) @(posedge ref_clk);
		end
	endtask : send_byte
	// Every line is closed by one line feed.
	task automatic send_line(input string s);
		for (int i = 0; i < s.len(); i++) send_byte(s[i]);
		send_byte(CH_LF);
	endtask : send_line
	////////////////////////////////////////
	// Samples reply bits mid-cell on the falling edge, away from the edge that moves the line.
	// A bad stop bit yields 8'hFF so it never matches.
	initial begin
		forever begin
			@(negedge ref_clk);
			if (txd === 1'b0) begin
				repeat (BIT_CYCLES / 2) @(negedge ref_clk);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_CYCLES) @(negedge ref_clk);
					b[i] = txd;
				end
				repeat (BIT_CYCLES) @(negedge ref_clk);
				got.push_back(txd === 1'b1 ? b : 8'hFF);
			end
		end
	end
endmodule : gmc_host_model
